/* caf_pkg.sv */
// caf_pkg: constants, types and helpers of the acceptance filter block
// assumes a 16-bit register view held in the low half of a 32-bit bus
package caf_pkg;

  localparam int          CAF_ADR_W       = 8;
  localparam logic [7:0]  CAF_ADR_ENABLE  = 8'h00;
  localparam logic [7:0]  CAF_ADR_ROUTE0  = 8'h04;
  localparam logic [7:0]  CAF_ADR_MSEL0   = 8'h14;
  localparam logic [7:0]  CAF_ADR_FULL    = 8'h1C;
  localparam logic [1:0]  CAF_REGION_SID  = 2'h1;
  localparam logic [1:0]  CAF_REGION_EID  = 2'h2;

  localparam logic [15:0] CAF_ENABLE_RST  = 16'hFFFF;
  localparam logic [15:0] CAF_ROUTE_RST   = 16'h0000;
  localparam logic [15:0] CAF_MSEL_RST    = 16'h0000;
  localparam logic [15:0] CAF_FULL_RST    = 16'h0000;
  localparam logic [15:0] CAF_FULL_IMPL   = 16'h7FFF;
  localparam logic [15:0] CAF_SID_IMPL    = 16'hFFEB;

  localparam int          CAF_SID_HI      = 15;
  localparam int          CAF_SID_LO      = 5;
  localparam int          CAF_EXTENDED_FRAME_SELECT_POS   = 3;
  localparam int          CAF_EIDH_HI     = 1;
  localparam int          CAF_EIDH_LO     = 0;

  localparam logic [3:0]  CAF_PTR_FIFO    = 4'hF;
  localparam logic [3:0]  CAF_LAST_FILTER = 4'hF;
  localparam logic [1:0]  CAF_MSK_RSVD    = 2'h3;
  localparam logic [4:0]  CAF_SCAN_END    = 5'h10;

  typedef struct packed {
    logic        ide;
    logic [10:0] sid;
    logic [17:0] eid;
  } caf_frame_type;

  typedef struct packed {
    logic [15:0] sid;
    logic [15:0] eid;
  } caf_ident_type;

  typedef caf_ident_type [2:0] caf_mask_set_type;

  typedef struct packed {
    logic       valid;
    logic [3:0] filter;
    logic       to_fifo;
    logic [3:0] buffer;
  } caf_hit_type;

  // byte-lane merge of a 16-bit register write
  function automatic logic [15:0] caf_lane_write(input logic [15:0] old_v,
                                                 input logic [15:0] new_v,
                                                 input logic [1:0]  sel);
    caf_lane_write = {sel[1] ? new_v[15:8] : old_v[15:8],
                      sel[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

endpackage

/* caf_ident_mem.sv */
// caf_ident_mem: sixteen filter identifier entries, two registered read ports
// assumes writes arrive already lane-merged from the bus slave
`timescale 1ns/10ps
`default_nettype none
module caf_ident_mem
  import caf_pkg::*;
(
  input  wire logic          clock_i,
  input  wire logic          sys_rst_i,
  input  wire logic          wr_sid_i,
  input  wire logic          wr_eid_i,
  input  wire logic [3:0]    wr_idx_i,
  input  wire logic [15:0]   wr_data_i,
  input  wire logic [3:0]    rd_a_idx_i,
  output caf_ident_type      rd_a_o,
  input  wire logic [3:0]    rd_b_idx_i,
  output caf_ident_type      rd_b_o
);

  // no reset on the array: entries stay undefined until written
  caf_ident_type mem_q [16];

  always_ff @(posedge clock_i)
  begin
    if (wr_sid_i)
      mem_q[wr_idx_i].sid <= wr_data_i & CAF_SID_IMPL;
    if (wr_eid_i)
      mem_q[wr_idx_i].eid <= wr_data_i;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rd_a_o <= '0;
      rd_b_o <= '0;
    end
    else
    begin
      rd_a_o <= mem_q[rd_a_idx_i];
      rd_b_o <= mem_q[rd_b_idx_i];
    end
  end

endmodule
`default_nettype wire

/* caf_match.sv */
// caf_match: combinational compare of one frame against one filter and mask
// assumes all inputs are stable registered values of the same clock
`timescale 1ns/10ps
`default_nettype none
module caf_match
  import caf_pkg::*;
(
  input  wire caf_frame_type frame_i,
  input  wire caf_ident_type filt_i,
  input  wire caf_ident_type mask_i,
  input  wire logic          enable_i,
  output logic               hit_o
);

  wire logic [10:0] sid_diff  = frame_i.sid ^ filt_i.sid[CAF_SID_HI:CAF_SID_LO];
  wire logic [1:0]  eidh_diff = frame_i.eid[17:16] ^ filt_i.sid[CAF_EIDH_HI:CAF_EIDH_LO];
  wire logic [15:0] eidl_diff = frame_i.eid[15:0] ^ filt_i.eid;

  // a clear mask bit turns the compare of that bit off
  wire logic sid_ok  = (sid_diff & mask_i.sid[CAF_SID_HI:CAF_SID_LO]) == 11'h000;
  wire logic eidh_ok = (eidh_diff & mask_i.sid[CAF_EIDH_HI:CAF_EIDH_LO]) == 2'h0;
  wire logic eidl_ok = (eidl_diff & mask_i.eid) == 16'h0000;

  // standard frames carry no extended bits, so only the standard part counts
  wire logic id_ok   = sid_ok & (~frame_i.ide | (eidh_ok & eidl_ok));

  wire logic restrict_on = mask_i.sid[CAF_EXTENDED_FRAME_SELECT_POS];
  wire logic type_ok = ~restrict_on | (filt_i.sid[CAF_EXTENDED_FRAME_SELECT_POS] == frame_i.ide);

  assign hit_o = enable_i & id_ok & type_ok;

endmodule
`default_nettype wire

/* caf_filter_top.sv */
// caf_filter_top: acceptance filter, filter routing and buffer full flags
// assumes a classic Wishbone master and a receive path on the same clock
// Operation
// - pointer code 1111 sends a hit of that filter into the receive FIFO.
// - pointer codes 0 to 14 send a hit into the buffer of that index.
// - filters 11,10,9,8 routing nibbles share one register, top nibble down.
// - filters 15,14,13,12 routing nibbles share a second register, 15 on top.
// - standard identifier bits 15:5 must equal compared message bits to match.
// - with restriction on, a set extended flag accepts only extended frames.
// - with restriction on, a clear extended flag accepts only standard frames.
// - low two bits of the standard register hold extended bits 17 and 16.
// - extended bits 15:0 of each filter sit in their own register.
// - mask source codes 00, 01, 10 pick mask sets 0, 1, 2.
// - code 11 is reserved; filters 7..0 fill the first select register.
// - filters 15..8 fill the second select register, filter 15 on top.
// - bits 4 and 2 of each standard identifier register read zero.
// - a set mask bit compares that identifier bit, a clear one ignores it.
// - with restriction off, either frame type passes on a masked match.
// - only filters whose enable bit is set take part in acceptance.
// - a message stored into a buffer sets that buffer's full flag.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module caf_filter_top
  import caf_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [CAF_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 frame_valid_i,
  input  wire caf_frame_type        frame_i,
  output logic                      frame_ready_o,
  input  wire caf_mask_set_type     mask_i,
  output caf_hit_type               hit_o,
  output logic                      miss_o
);

  typedef enum logic [1:0] {
    CAF_IDLE = 2'b01,
    CAF_SCAN = 2'b10
  } caf_state_type;

  logic                 ack_q;
  logic                 pend_q;
  logic [31:0]          dat_q;
  logic [15:0]          en_q;
  logic [3:0][15:0]     route_q;
  logic [1:0][15:0]     msel_q;
  logic [15:0]          full_q;
  logic [15:0]          full_d;
  caf_state_type        state_q;
  caf_state_type        state_d;
  logic [4:0]           cnt_q;
  logic                 cmp_vld_q;
  logic [3:0]           cmp_idx_q;
  caf_frame_type        frame_q;
  caf_hit_type          hit_q;
  caf_hit_type          hit_d;
  logic                 miss_q;
  logic                 rdy_q;
  logic [15:0]          rd_word;
  caf_ident_type        bus_ent;
  caf_ident_type        scan_ent;
  logic                 match_hit;

  // bus decode: answer on the second edge, so mem read data is ready
  wire logic       bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic       ack_d     = bus_req & pend_q;
  wire logic       wr_commit = ack_d & wb_we_i;
  wire logic [7:0] adr_w     = {wb_adr_i[7:2], 2'b00};
  wire logic [3:0] fidx      = wb_adr_i[5:2];
  wire logic [15:0] wdat     = wb_dat_i[15:0];
  wire logic [1:0] lanes     = wb_sel_i[1:0];
  wire logic       sel_en    = adr_w == CAF_ADR_ENABLE;
  wire logic       sel_full  = adr_w == CAF_ADR_FULL;
  wire logic       in_sid    = wb_adr_i[7:6] == CAF_REGION_SID;
  wire logic       in_eid    = wb_adr_i[7:6] == CAF_REGION_EID;
  wire logic [3:0] sel_route;
  wire logic [1:0] sel_msel;

  for (genvar k = 0; k < 4; k++)
  begin : g_route_dec
    assign sel_route[k] = adr_w == CAF_ADR_ROUTE0 + 8'(4 * k);
  end

  for (genvar k = 0; k < 2; k++)
  begin : g_msel_dec
    assign sel_msel[k] = adr_w == CAF_ADR_MSEL0 + 8'(4 * k);
  end

  // unmapped words still get an ack, reading zero and ignoring writes
  always_comb
  begin
    rd_word = 16'h0000;
    if (sel_en)
      rd_word = en_q;
    for (int k = 0; k < 4; k++)
      if (sel_route[k])
        rd_word = route_q[k];
    for (int k = 0; k < 2; k++)
      if (sel_msel[k])
        rd_word = msel_q[k];
    if (sel_full)
      rd_word = full_q;
    if (in_sid)
      rd_word = bus_ent.sid;
    if (in_eid)
      rd_word = bus_ent.eid;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ack_q  <= 1'b0;
      pend_q <= 1'b0;
      dat_q  <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= ack_d;
      pend_q <= bus_req;
      if (ack_d)
        dat_q <= {16'h0000, rd_word};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      en_q    <= CAF_ENABLE_RST;
      route_q <= {4{CAF_ROUTE_RST}};
      msel_q  <= {2{CAF_MSEL_RST}};
      full_q  <= CAF_FULL_RST;
    end
    else
    begin
      if (wr_commit & sel_en)
        en_q <= caf_lane_write(en_q, wdat, lanes);
      for (int k = 0; k < 4; k++)
        if (wr_commit & sel_route[k])
          route_q[k] <= caf_lane_write(route_q[k], wdat, lanes);
      for (int k = 0; k < 2; k++)
        if (wr_commit & sel_msel[k])
          msel_q[k] <= caf_lane_write(msel_q[k], wdat, lanes);
      full_q <= full_d;
    end
  end

  // writing zero clears a flag, a new hit in the same cycle wins
  wire logic [15:0] full_wr  = (wr_commit & sel_full) ?
                               caf_lane_write(full_q, full_q & wdat, lanes) : full_q;
  wire logic [15:0] full_set = (hit_d.valid & ~hit_d.to_fifo) ?
                               (16'h0001 << hit_d.buffer) : 16'h0000;
  assign full_d = (full_wr | full_set) & CAF_FULL_IMPL;

  // identifier store, bus writes lane-merged against the bus read port
  caf_ident_mem u_mem (
    .clock_i    (clock_i),
    .sys_rst_i  (sys_rst_i),
    .wr_sid_i   (wr_commit & in_sid),
    .wr_eid_i   (wr_commit & in_eid),
    .wr_idx_i   (fidx),
    .wr_data_i  (caf_lane_write(in_sid ? bus_ent.sid : bus_ent.eid, wdat, lanes)),
    .rd_a_idx_i (fidx),
    .rd_a_o     (bus_ent),
    .rd_b_idx_i (cnt_q[3:0]),
    .rd_b_o     (scan_ent)
  );

  // selection for the filter under compare
  wire logic [63:0] route_flat = route_q;
  wire logic [31:0] msel_flat  = msel_q;
  wire logic [3:0]  cur_route  = route_flat[{cmp_idx_q, 2'b00} +: 4];
  wire logic [1:0]  cur_msel   = msel_flat[{cmp_idx_q, 1'b0} +: 2];
  wire logic        cur_rsvd   = cur_msel == CAF_MSK_RSVD;
  wire logic        cur_en     = en_q[cmp_idx_q];
  wire caf_ident_type cur_mask = cur_rsvd ? '0 : mask_i[cur_msel];

  caf_match u_match (
    .frame_i  (frame_q),
    .filt_i   (scan_ent),
    .mask_i   (cur_mask),
    .enable_i (cur_en & ~cur_rsvd),
    .hit_o    (match_hit)
  );

  // filters are walked 0 to 15, so the first hit is the lowest numbered
  wire logic found    = cmp_vld_q & match_hit;
  wire logic last_cmp = cmp_vld_q & (cmp_idx_q == CAF_LAST_FILTER);
  wire logic done     = found | last_cmp;
  wire logic start    = frame_valid_i & rdy_q;
  wire logic scanning = state_q == CAF_SCAN;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      CAF_IDLE:
        if (start)
          state_d = CAF_SCAN;
      CAF_SCAN:
        if (done)
          state_d = CAF_IDLE;
    endcase
  end

  always_comb
  begin
    hit_d         = '0;
    hit_d.valid   = found;
    hit_d.filter  = cmp_idx_q;
    hit_d.to_fifo = found & (cur_route == CAF_PTR_FIFO);
    hit_d.buffer  = (cur_route == CAF_PTR_FIFO) ? 4'h0 : cur_route;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q   <= CAF_IDLE;
      cnt_q     <= 5'h00;
      cmp_vld_q <= 1'b0;
      cmp_idx_q <= 4'h0;
      frame_q   <= '0;
      hit_q     <= '0;
      miss_q    <= 1'b0;
      rdy_q     <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      cnt_q     <= start ? 5'h00 : (scanning & ~cnt_q[4]) ? cnt_q + 5'h01 : cnt_q;
      cmp_vld_q <= scanning & ~done & (cnt_q != CAF_SCAN_END);
      cmp_idx_q <= cnt_q[3:0];
      if (start)
        frame_q <= frame_i;
      hit_q     <= hit_d;
      miss_q    <= last_cmp & ~found;
      rdy_q     <= state_d == CAF_IDLE;
    end
  end

  assign hit_o         = hit_q;
  assign miss_o        = miss_q;
  assign frame_ready_o = rdy_q;

  a_fifo_code: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hit_o.valid |-> hit_o.to_fifo == ($past(cur_route) == 4'hF))
    else $error("fifo route code not honoured");

  a_buffer_index: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hit_o.valid && !hit_o.to_fifo |-> hit_o.buffer == $past(cur_route))
    else $error("buffer index differs from pointer");

  a_route_pack_lo: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cmp_idx_q == 4'h8 |-> cur_route == route_q[2][3:0])
    else $error("filter 8 pointer not in low nibble");

  a_route_pack_hi: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cmp_idx_q == 4'hF |-> cur_route == route_q[3][15:12])
    else $error("filter 15 pointer not in top nibble");

  a_ident_match: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hit_o.valid |-> $past((frame_q.sid ^ scan_ent.sid[15:5]) & cur_mask.sid[15:5]) == 11'h000)
    else $error("hit with masked standard bits unequal");

  a_type_only: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hit_o.valid && $past(cur_mask.sid[3])
    |-> $past(scan_ent.sid[3]) == $past(frame_q.ide))
    else $error("frame type restriction ignored");

  a_mask_pick: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cmp_vld_q && cur_msel == 2'h1 |-> cur_mask == mask_i[1])
    else $error("mask source 01 not mask set 1");

  a_mask_reserved: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hit_o.valid |-> $past(cur_msel) != 2'h3)
    else $error("hit through reserved mask code");

  a_msel_pack: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cmp_idx_q == 4'h8 |-> cur_msel == msel_q[1][1:0])
    else $error("filter 8 mask source misplaced");

  a_sid_unimpl: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    ack_d && !wb_we_i && in_sid |=> wb_dat_o[4] == 1'b0 && wb_dat_o[2] == 1'b0)
    else $error("unimplemented identifier bit read as one");

  a_filter_enable: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hit_o.valid |-> $past(cur_en))
    else $error("disabled filter produced a hit");

  a_full_set: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    hit_o.valid && !hit_o.to_fifo |-> full_q[hit_o.buffer])
    else $error("full flag not set on buffer store");

  a_scan_bound: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    start |-> ##[3:18] (hit_o.valid || miss_o))
    else $error("scan did not finish within sixteen filters");

  a_ack_timing: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not on the second edge");

endmodule
`default_nettype wire

/* caf_rx_model.sv */
// caf_rx_model: receive path model, offers frames and times the answer
// assumes the filter answers each taken frame with one hit or miss pulse
`timescale 1ns/10ps
`default_nettype none
module caf_rx_model
  import caf_pkg::*;
(
  input  wire logic    clock_i,
  input  wire logic    frame_ready_i,
  input  wire caf_hit_type hit_i,
  input  wire logic    miss_i,
  output logic         frame_valid_o,
  output caf_frame_type frame_o
);
  initial
  begin
    frame_valid_o = 1'b0;
    frame_o       = '0;
  end

  // gap gives idle cycles first, so slow and back-to-back senders both occur
  task automatic send(input caf_frame_type f, input int gap, output caf_hit_type h,
                      output logic m, output int n);
    repeat (gap) @(posedge clock_i);
    @(posedge clock_i);
    frame_valid_o <= 1'b1;
    frame_o       <= f;
    do @(posedge clock_i); while (frame_ready_i !== 1'b1);
    frame_valid_o <= 1'b0;
    // stale lines flip so nothing can lean on a held value
    frame_o       <= ~f;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (hit_i.valid !== 1'b1 && miss_i !== 1'b1 && n < 40);
    h = hit_i;
    m = miss_i;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// tb_top: self-checking bench of the acceptance filter over Wishbone
// assumes the receive path model and the filter share one 50 MHz clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("MISMATCH t=%0t %s", $time, msg); \
    end \
  end
module tb_top;
  import caf_pkg::*;
  localparam logic [31:0] PTRS = 32'hE71F5FE0;
  logic             clock_i;
  logic             sys_rst_i;
  logic             wb_cyc;
  logic             wb_stb;
  logic             wb_we;
  logic [7:0]       wb_adr;
  logic [3:0]       wb_sel;
  logic [31:0]      wb_wdat;
  logic [31:0]      wb_rdat;
  logic             wb_ack;
  logic             frame_valid;
  caf_frame_type    frame;
  logic             frame_ready;
  caf_mask_set_type mask;
  caf_hit_type      hit;
  logic             miss;
  int               n_fail;
  int               n_checks;
  int               cycles;
  logic [15:0]      rd;
  logic [15:0]      full_e;
  caf_hit_type      h;
  logic             m;
  int               n;

  caf_filter_top u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .frame_valid_i(frame_valid),
    .frame_i(frame), .frame_ready_o(frame_ready), .mask_i(mask), .hit_o(hit), .miss_o(miss));
  caf_rx_model u_rx (.clock_i(clock_i), .frame_ready_i(frame_ready), .hit_i(hit),
    .miss_i(miss), .frame_valid_o(frame_valid), .frame_o(frame));

  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // sized for about nine times the expected run
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  function automatic logic [3:0] ptr_of(input logic [3:0] k);
    ptr_of = PTRS[{k[2:0], 2'b00} +: 4];
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] s);
    @(posedge clock_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_sel  <= {2'b00, s};
    wb_wdat <= {16'h0000, d};
    do @(posedge clock_i); while (wb_ack !== 1'b1);
    rd = wb_rdat[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000, 2'b11);
    `CHK(rd, e, "register read")
  endtask

  task automatic fchk(input logic ide, input logic [10:0] sid, input logic [17:0] eid,
                      input logic [3:0] k, input logic hit_exp);
    logic [3:0] p;
    p = ptr_of(k);
    u_rx.send({ide, sid, eid}, sid[0] ? 3 : 0, h, m, n);
    if (hit_exp)
    begin
      `CHK({h.valid, h.filter, h.to_fifo, h.buffer, m},
           {1'b1, k, p == CAF_PTR_FIFO, (p == CAF_PTR_FIFO) ? 4'h0 : p, 1'b0}, "hit")
      `CHK(n, 3 + int'(k), "hit latency")
    end
    else
    begin
      `CHK({h.valid, m}, 2'b01, "miss")
      `CHK(n, 18, "miss latency")
    end
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    wb_cyc    = 1'b0;
    wb_stb    = 1'b0;
    wb_we     = 1'b0;
    wb_adr    = 8'h00;
    wb_sel    = 4'h0;
    wb_wdat   = 32'h0000_0000;
    n_fail    = 0;
    n_checks  = 0;
    cycles    = 0;
    full_e    = 16'h0000;
    // set 2 compares all with restriction, set 1 ignores all, set 0 compares all
    mask = {16'hFFEB, 16'hFFFF, 32'h0000_0000, 16'hFFE3, 16'hFFFF};
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rchk(CAF_ADR_ENABLE, 16'hFFFF);
    for (int a = 4; a <= 8'h18; a += 4)
      rchk(8'(a), 16'h0000);
    rchk(CAF_ADR_FULL, 16'h0000);
    rchk(8'h3C, 16'h0000);
    wb(1'b1, 8'h04, 16'h1234, 2'b01);
    rchk(8'h04, 16'h0034);
    wb(1'b1, 8'h40, 16'hFFFF, 2'b11);
    rchk(8'h40, 16'hFFEB);
    for (int k = 0; k < 16; k++)
    begin
      wb(1'b1, 8'(8'h40 + 4 * k), 16'(k << 5), 2'b11);
      wb(1'b1, 8'(8'h80 + 4 * k), 16'(16'hA000 + k), 2'b11);
    end
    rchk(8'hBC, 16'hA00F);
    wb(1'b1, 8'h0C, 16'h5FE0, 2'b11);
    wb(1'b1, 8'h10, 16'hE71F, 2'b11);
    rchk(8'h0C, 16'h5FE0);
    rchk(8'h10, 16'hE71F);
    wb(1'b1, CAF_ADR_ENABLE, 16'hFF00, 2'b11);
    wb(1'b1, 8'h18, 16'h8000, 2'b11);
    rchk(8'h18, 16'h8000);
    $display("test registers done");

    for (int k = 8; k < 16; k++)
    begin
      fchk(1'b0, 11'(k), 18'h0, 4'(k), 1'b1);
      if (ptr_of(4'(k)) != CAF_PTR_FIFO)
        full_e[ptr_of(4'(k))] = 1'b1;
    end
    rchk(CAF_ADR_FULL, full_e);
    wb(1'b1, CAF_ADR_FULL, 16'h4000, 2'b11);
    rchk(CAF_ADR_FULL, 16'h4000);
    fchk(1'b0, 11'h7FF, 18'h0, 4'h0, 1'b0);
    $display("test routing done");

    fchk(1'b1, 11'd15, 18'h0A00F, 4'h0, 1'b0);
    wb(1'b1, 8'h7C, 16'h01E8, 2'b11);
    fchk(1'b1, 11'd15, 18'h0A00F, 4'hF, 1'b1);
    fchk(1'b0, 11'd15, 18'h0, 4'h0, 1'b0);
    wb(1'b1, 8'h78, 16'h01C8, 2'b11);
    fchk(1'b0, 11'd14, 18'h0, 4'hE, 1'b1);
    fchk(1'b1, 11'd14, 18'h0A00E, 4'hE, 1'b1);
    fchk(1'b1, 11'd14, 18'h1A00E, 4'h0, 1'b0);
    fchk(1'b1, 11'd14, 18'h0A00F, 4'h0, 1'b0);
    wb(1'b1, CAF_ADR_ENABLE, 16'h7F00, 2'b11);
    fchk(1'b1, 11'd15, 18'h0A00F, 4'h0, 1'b0);
    wb(1'b1, CAF_ADR_ENABLE, 16'hFF00, 2'b11);
    $display("test frame type done");

    // filter 8 restricted to standard frames, filter 12 the ignore-all set
    wb(1'b1, 8'h18, 16'h0102, 2'b11);
    fchk(1'b1, 11'd8, 18'h0, 4'hC, 1'b1);
    fchk(1'b0, 11'd9, 18'h0, 4'h9, 1'b1);
    fchk(1'b0, 11'd13, 18'h0, 4'hC, 1'b1);
    fchk(1'b1, 11'h7FF, 18'h3FFFF, 4'hC, 1'b1);
    $display("test priority done");
    print_verdict();
  end
endmodule
`default_nettype wire
